/* File: src/xgpio_defs.svh */
// Purpose : constants for the extension-bus gpio port
// Assumes : 16-bit word bus, byte addresses as printed
// Notes   : definitions only
`ifndef XGPIO_DEFS_SVH
`define XGPIO_DEFS_SVH
// register byte addresses on the extension bus
`define ADDR_PORT_DATA        16'hEB80
`define ADDR_PORT_DATA_SET    16'hEB82
`define ADDR_PORT_DATA_CLEAR  16'hEB84
`define ADDR_LINE_DIR         16'hEB86
`define ADDR_LINE_DIR_SET     16'hEB88
`define ADDR_LINE_DIR_CLEAR   16'hEB8A
`define ADDR_DRIVE_MODE       16'hEB8C
`define ADDR_DRIVE_MODE_SET   16'hEB8E
`define ADDR_DRIVE_MODE_CLEAR 16'hEB90
// input-only port data register, own choice
`define ADDR_IN_PORT_DATA     16'hEBC0
// reset value and read-zero word
`define RST_WORD              16'h0000
`define RD_ZERO               16'h0000
`endif

/* File: src/xgpio_pkg.sv */
// Purpose : types for the extension-bus gpio port
// Assumes : 16-bit data words
// Notes   : constants live in xgpio_defs.svh
package xgpio_pkg;
	// ************************************
	// bus request carrier
	// ************************************
	typedef struct packed {
		logic        sel;   // access strobe
		logic        wr;    // 1 write, 0 read
		logic [15:0] addr;  // byte address
		logic [15:0] wdata; // write word
	} bus_req_t;
	// write operation kind for one register group
	typedef enum logic [3:0] {
		OP_NONE  = 4'h1,
		OP_LOAD  = 4'h2,
		OP_SET   = 4'h4,
		OP_CLEAR = 4'h8
	} wr_op_t;
endpackage

/* File: src/xgpio_sync.sv */
// Purpose : two-flop synchroniser for a pin vector
// Assumes : single clock domain clk_i
// Notes   : first stage feeds only the second
`timescale 1ns/1ns
module xgpio_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q; // first stage
	logic [WIDTH-1:0] meta_d; // first stage next
	logic [WIDTH-1:0] sync_q; // second stage
	logic [WIDTH-1:0] sync_d; // second stage next
	// next values
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end
	// registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign sync_o = sync_q;
endmodule

/* File: src/xgpio_port.sv */
// Purpose : 16-bit gpio port plus input-only port on extension bus
// Assumes : single-cycle word accesses, read data registered
// Notes   : set/clear companions replace bit addressing
//
// Behaviour
// - data set register ones set data bits
// - data clear register ones clear data bits
// - direction bit: zero input, one output
// - direction set register ones set bits
// - direction clear register ones clear bits
// - drive mode: zero push-pull, one open-drain
// - drive set register ones set bits
// - drive clear register ones clear bits
// - input port needs global and own enable
// - whole-word accesses only, no bit addressing
// - second port input only, never driven
// - gpio port needs global and port enable
`timescale 1ns/1ns
`include "xgpio_defs.svh"
module xgpio_port
	import xgpio_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire bus_req_t         req_i,
	output logic      [15:0]      rdata_o,
	output logic                  rvalid_o,
	input  wire logic             global_en_i,
	input  wire logic             port_en_i,
	input  wire logic             in_port_en_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe_o,
	input  wire logic [WIDTH-1:0] in_pin_i
);
	// ************************************
	// state and helpers
	// ************************************
	logic [WIDTH-1:0] data_q, data_d;   // output latch
	logic [WIDTH-1:0] dir_q, dir_d;     // line direction
	logic [WIDTH-1:0] mode_q, mode_d;   // drive mode
	logic [15:0]      rdata_q, rdata_d; // read word
	logic             rvalid_q, rvalid_d;
	logic [WIDTH-1:0] pin_s;            // synced gpio pins
	logic [WIDTH-1:0] in_pin_s;         // synced input-only pins
	logic             port_on;          // gpio port enabled
	logic             in_on;            // input port enabled
	logic             wr_hit;           // write strobe
	wr_op_t           op_data, op_dir, op_mode;

	// decode a write onto one register group
	function automatic wr_op_t group_op(input logic [15:0] a,
		input logic [15:0] base, input logic [15:0] sa,
		input logic [15:0] ca);
		if (a == base)
			group_op = OP_LOAD;
		else if (a == sa)
			group_op = OP_SET;
		else if (a == ca)
			group_op = OP_CLEAR;
		else
			group_op = OP_NONE;
	endfunction

	// apply a whole-word write operation to a group
	function automatic logic [WIDTH-1:0] group_next(input wr_op_t op,
		input logic [WIDTH-1:0] cur, input logic [WIDTH-1:0] w);
		case (op)
			OP_LOAD:  group_next = w;
			OP_SET:   group_next = cur | w;
			OP_CLEAR: group_next = cur & ~w;
			default:  group_next = cur;
		endcase
	endfunction

	// ************************************
	// pin synchronisers
	// ************************************
	xgpio_sync #(.WIDTH(2*WIDTH)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i ({in_pin_i, pin_i}),
		.sync_o  ({in_pin_s, pin_s})
	);

	// ************************************
	// register writes
	// ************************************
	// gpio and input port enables, write strobe
	assign port_on = global_en_i & port_en_i;
	assign in_on   = global_en_i & in_port_en_i;
	assign wr_hit  = req_i.sel & req_i.wr & port_on;

	// next values of the three groups, word writes only
	always_comb
	begin
		op_data = wr_hit ? group_op(req_i.addr, `ADDR_PORT_DATA,
			`ADDR_PORT_DATA_SET, `ADDR_PORT_DATA_CLEAR) : OP_NONE;
		op_dir  = wr_hit ? group_op(req_i.addr, `ADDR_LINE_DIR,
			`ADDR_LINE_DIR_SET, `ADDR_LINE_DIR_CLEAR) : OP_NONE;
		op_mode = wr_hit ? group_op(req_i.addr, `ADDR_DRIVE_MODE,
			`ADDR_DRIVE_MODE_SET, `ADDR_DRIVE_MODE_CLEAR) : OP_NONE;
		data_d = group_next(op_data, data_q, req_i.wdata[WIDTH-1:0]);
		dir_d  = group_next(op_dir, dir_q, req_i.wdata[WIDTH-1:0]);
		mode_d = group_next(op_mode, mode_q, req_i.wdata[WIDTH-1:0]);
	end

	// ************************************
	// register reads
	// ************************************
	// read mux, answer one cycle after the strobe
	always_comb
	begin
		rvalid_d = req_i.sel & ~req_i.wr;
		rdata_d  = `RD_ZERO;
		if (req_i.sel & ~req_i.wr)
		begin
			case (req_i.addr)
				`ADDR_PORT_DATA:
					if (port_on)
						rdata_d = 16'((dir_q & data_q) | (~dir_q & pin_s));
				`ADDR_LINE_DIR:
					if (port_on)
						rdata_d = 16'(dir_q);
				`ADDR_DRIVE_MODE:
					if (port_on)
						rdata_d = 16'(mode_q);
				`ADDR_IN_PORT_DATA:
					if (in_on)
						rdata_d = 16'(in_pin_s);
				// write-only and unmapped read zero
				default:
					rdata_d = `RD_ZERO;
			endcase
		end
	end

	// ************************************
	// state registers
	// ************************************
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_q   <= WIDTH'(`RST_WORD);
			dir_q    <= WIDTH'(`RST_WORD);
			mode_q   <= WIDTH'(`RST_WORD);
			rdata_q  <= `RST_WORD;
			rvalid_q <= 1'b0;
		end
		else
		begin
			data_q   <= data_d;
			dir_q    <= dir_d;
			mode_q   <= mode_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// ************************************
	// pin drivers
	// ************************************
	// direction and drive mode
	always_comb
	begin
		pin_o    = data_q;
		pin_oe_o = dir_q & ~(mode_q & data_q);
		if (!port_on)
		begin
			pin_oe_o = '0;
		end
	end
	// input-only port has no driver outputs at all
	assign rdata_o  = rdata_q;
	assign rvalid_o = rvalid_q;
endmodule

/* File: dv/xgpio_pins_model.sv */
// Purpose: outside circuitry on the gpio lines
// Assumes: a pull-up on every line
// Notes: a released line reads high
`timescale 1ns/1ns
module xgpio_pins_model (
	input  wire logic [15:0] drv_i, // level the port drives
	input  wire logic [15:0] oe_i,  // high while the port drives
	output logic      [15:0] lvl_o  // level seen on the wire
);
	assign lvl_o = (oe_i & drv_i) | ~oe_i;
endmodule

/* File: dv/xgpio_port_sva.sv */
// Purpose: port checks on the gpio top
// Assumes: one clock, async reset
// Notes: sees the top ports only
`timescale 1ns/1ns
`include "xgpio_defs.svh"
module xgpio_port_sva
	import xgpio_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire bus_req_t    req_i,
	input wire logic [15:0] rdata_o,
	input wire logic        rvalid_o,
	input wire logic        global_en_i,
	input wire logic        port_en_i,
	input wire logic        in_port_en_i,
	input wire logic [15:0] pin_o,
	input wire logic [15:0] pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// an accepted gpio write to one address
	sequence s_wr(a);
		req_i.sel && req_i.wr && global_en_i && port_en_i
			&& req_i.addr == a;
	endsequence
	property p_set;
		s_wr(`ADDR_PORT_DATA_SET) |=>
			pin_o == ($past(pin_o) | $past(req_i.wdata));
	endproperty
	a_set: assert property (p_set) else $error("set");
	property p_clr;
		s_wr(`ADDR_PORT_DATA_CLEAR) |=>
			pin_o == ($past(pin_o) & ~$past(req_i.wdata));
	endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_dclr;
		s_wr(`ADDR_LINE_DIR_CLEAR) |=>
			(pin_oe_o & $past(req_i.wdata)) == 16'h0000;
	endproperty
	a_dclr: assert property (p_dclr) else $error("dir");
	property p_od;
		s_wr(`ADDR_DRIVE_MODE_SET) |=>
			(pin_oe_o & pin_o & $past(req_i.wdata)) == 16'h0000;
	endproperty
	a_od: assert property (p_od) else $error("drain");
	property p_en;
		!(global_en_i && port_en_i) |-> pin_oe_o == 16'h0000;
	endproperty
	a_en: assert property (p_en) else $error("enable");
	property p_inoff;
		req_i.sel && !req_i.wr && req_i.addr == `ADDR_IN_PORT_DATA
			&& !(global_en_i && in_port_en_i) |=> rdata_o == 16'h0000;
	endproperty
	a_inoff: assert property (p_inoff) else $error("inport");
	property p_inwr;
		req_i.sel && req_i.wr && req_i.addr == `ADDR_IN_PORT_DATA
			|=> $stable(pin_o);
	endproperty
	a_inwr: assert property (p_inwr) else $error("inwrite");
	property p_rv;
		rvalid_o == $past(req_i.sel && !req_i.wr);
	endproperty
	a_rv: assert property (p_rv) else $error("rvalid");
endmodule

/* File: dv/extension_gpio_port_set_clear_bench.sv */
// Purpose: bench for the extension gpio port
// Assumes: one idle cycle between accesses
// Notes: expected words worked out by hand
`timescale 1ns/1ns
`include "xgpio_defs.svh"
module extension_gpio_port_set_clear_bench
	import xgpio_pkg::*;
;
	logic        clk_i = 0, rst_n_i = 0, ge = 0, pe = 0, ie = 0, rv;
	bus_req_t    req = '0;
	logic [15:0] rd, pin, pout, poe, inp = 16'hA55A;
	logic [15:0] wo[7] = '{16'hEB82, 16'hEB84, 16'hEB88, 16'hEB8A,
		16'hEB8E, 16'hEB90, 16'hEB92};
	int          mismatches = 0, check_count = 0;
	always #50 clk_i = ~clk_i;
	xgpio_pins_model pm (.drv_i(pout), .oe_i(poe), .lvl_o(pin));
	xgpio_port dut (.clk_i, .rst_n_i, .req_i(req), .rdata_o(rd),
		.rvalid_o(rv), .global_en_i(ge), .port_en_i(pe),
		.in_port_en_i(ie), .pin_i(pin), .pin_o(pout),
		.pin_oe_o(poe), .in_pin_i(inp));
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// one access, held across its taking edge
	task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
		@(posedge clk_i);
		#10 req = '{1'h1, w, a, d};
		@(posedge clk_i);
		#10 req.sel = 1'h0;
	endtask
	task automatic rdc(logic [15:0] a, logic [15:0] e);
		acc(1'h0, a, 16'h0000);
		chk("rvalid", {15'h0000, rv}, 16'h0001);
		chk("rdata", rd, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		#10 rst_n_i = 1;
		ge = 1;
		pe = 1;
		repeat (3) @(posedge clk_i);
		rdc(`ADDR_PORT_DATA, 16'hFFFF);
		rdc(`ADDR_LINE_DIR, `RST_WORD);
		rdc(`ADDR_DRIVE_MODE, `RST_WORD);
		acc(1'h1, `ADDR_PORT_DATA, 16'h00F0);
		acc(1'h1, `ADDR_PORT_DATA_SET, 16'h0003);
		acc(1'h1, `ADDR_PORT_DATA_CLEAR, 16'h0030);
		acc(1'h1, `ADDR_LINE_DIR, 16'hFFFF);
		rdc(`ADDR_PORT_DATA, 16'h00C3);
		acc(1'h1, `ADDR_LINE_DIR_CLEAR, 16'hFF00);
		acc(1'h1, `ADDR_LINE_DIR_SET, 16'h0100);
		rdc(`ADDR_LINE_DIR, 16'h01FF);
		rdc(`ADDR_PORT_DATA, 16'hFEC3);
		acc(1'h1, `ADDR_DRIVE_MODE_SET, 16'h0003);
		chk("oe", poe, 16'h01FC);
		acc(1'h1, `ADDR_DRIVE_MODE_CLEAR, 16'h0001);
		rdc(`ADDR_DRIVE_MODE, 16'h0002);
		chk("oe", poe, 16'h01FD);
		// whole-word load of the drive mode group
		acc(1'h1, `ADDR_DRIVE_MODE, 16'h00F0);
		rdc(`ADDR_DRIVE_MODE, 16'h00F0);
		chk("oe", poe, 16'h013F);
		foreach (wo[i]) rdc(wo[i], `RD_ZERO);
		pe = 0;
		acc(1'h1, `ADDR_PORT_DATA_SET, 16'hFFFF);
		chk("oe", poe, 16'h0000);
		pe = 1;
		chk("pin", pout, 16'h00C3);
		rdc(`ADDR_IN_PORT_DATA, `RD_ZERO);
		ie = 1;
		acc(1'h1, `ADDR_IN_PORT_DATA, 16'h0000);
		rdc(`ADDR_IN_PORT_DATA, 16'hA55A);
		chk("pin", pout, 16'h00C3);
		// reset in mid-run clears every register
		@(posedge clk_i);
		#10 rst_n_i = 0;
		@(posedge clk_i);
		#10 chk("oe", poe, `RST_WORD);
		chk("pin", pout, `RST_WORD);
		chk("rdata", rd, `RST_WORD);
		@(posedge clk_i);
		#10 rst_n_i = 1;
		rdc(`ADDR_LINE_DIR, `RST_WORD);
		complete_run;
	end
	// watchdog against a hung access
	initial
	begin
		#200000;
		mismatches++;
		complete_run;
	end
endmodule
bind xgpio_port xgpio_port_sva sva (
	.clk_i        (clk_i),
	.rst_n_i      (rst_n_i),
	.req_i        (req_i),
	.rdata_o      (rdata_o),
	.rvalid_o     (rvalid_o),
	.global_en_i  (global_en_i),
	.port_en_i    (port_en_i),
	.in_port_en_i (in_port_en_i),
	.pin_o        (pin_o),
	.pin_oe_o     (pin_oe_o)
);
